// *** hdl/isl_pkg.sv ***
/*
 * Constants for the four-instruction decode and execute slice: opcode
 * patterns, field positions, widths and the instruction-cycle phase count.
 * Assumes a 10 MHz core clock where one oscillator period is one clk.
 */
package isl_pkg;
  localparam int ISL_IW = 14;
  localparam int ISL_DW = 8;
  localparam int ISL_AW = 7;
  localparam logic [5:0] ISL_OP_INC_SKIP = 6'h0f;
  localparam logic [5:0] ISL_OP_OR_WF = 6'h04;
  localparam logic [3:0] ISL_OP_MOV_LIT = 4'hc;
  localparam logic [5:0] ISL_OP_OR_LIT = 6'h38;
  localparam int ISL_OP6_HI = 13;
  localparam int ISL_OP6_LO = 8;
  localparam int ISL_OP4_LO = 10;
  localparam int ISL_DEST_BIT = 7;
  localparam int ISL_PHASES = 4;
  localparam logic [1:0] ISL_PH_LAST = 2'h3;
  localparam logic [1:0] ISL_PH_FIRST = 2'h0;
  localparam logic [7:0] ISL_W_RST = 8'h00;
  localparam logic [7:0] ISL_ONE = 8'h01;
  localparam logic [7:0] ISL_ZERO = 8'h00;
  localparam logic [13:0] ISL_NOP_WORD = 14'h0000;
  typedef enum logic [2:0] {
    ISL_K_NONE, ISL_K_INC_SKIP, ISL_K_OR_WF, ISL_K_MOV_LIT, ISL_K_OR_LIT
  } isl_kind_t;
endpackage

// *** hdl/isl_decode.sv ***
/*
 * Pure combinational opcode decode for the four supported instructions.
 * Assumes the instruction word is stable from the execute stage register.
 */
`timescale 1ns/10ps
`default_nettype none
module isl_decode
  import isl_pkg::*;
(
  input wire logic [ISL_IW-1:0] instr,
  output isl_kind_t kind
);
  wire logic [5:0] op6 = instr[ISL_OP6_HI:ISL_OP6_LO];
  wire logic [3:0] op4 = instr[ISL_OP6_HI:ISL_OP4_LO];
  // move_literal_to_work looks at four bits only, so the don't-cares never matter
  assign kind = (op6 == ISL_OP_INC_SKIP) ? ISL_K_INC_SKIP :
                (op6 == ISL_OP_OR_WF) ? ISL_K_OR_WF :
                (op4 == ISL_OP_MOV_LIT) ? ISL_K_MOV_LIT :
                (op6 == ISL_OP_OR_LIT) ? ISL_K_OR_LIT : ISL_K_NONE;
endmodule
`default_nettype wire

// *** hdl/isl_exec.sv ***
/*
 * Execute slice: latches a fetched word each instruction cycle, runs it
 * over four phases, and squashes the next word after a taken skip.
 * Assumes program memory presents fetch_word and the file register read
 * data combinationally; writes are single-clock strobes in the next cycle's phase 0.
 * The file address is registered, so it still names the write target
 * while the strobe stands, after the next word has been loaded.
 * Zero flag storage lives in the core: status_z_in is fed back from there,
 * and this slice only forwards it when an instruction leaves flags alone.
 * Squashed and unknown words both behave as no_operation.
 */
`timescale 1ns/10ps
`default_nettype none
module isl_exec
  import isl_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [ISL_IW-1:0] fetch_word,
  input wire logic [ISL_DW-1:0] file_rdata,
  input wire logic status_z_in,
  output logic fetch_req,
  output logic [ISL_AW-1:0] file_addr,
  output logic [ISL_DW-1:0] file_wdata,
  output logic file_we,
  output logic [ISL_DW-1:0] work,
  output logic status_z,
  output logic z_we,
  output logic skip_active,
  output logic unknown_op
);
  logic [1:0] phase_r;
  logic [ISL_IW-1:0] ir_r;
  logic [ISL_DW-1:0] w_r;
  logic squash_r;
  logic [ISL_AW-1:0] faddr_r;
  logic [ISL_DW-1:0] fwd_r;
  logic fwe_r;
  logic zwe_r;
  logic z_r;
  isl_kind_t kind;

  isl_decode u_dec (
    .instr(ir_r),
    .kind(kind)
  );

  wire logic last_ph = (phase_r == ISL_PH_LAST);
  wire logic first_ph = (phase_r == ISL_PH_FIRST);
  wire logic dest_file = ir_r[ISL_DEST_BIT];
  wire logic [ISL_DW-1:0] lit = ir_r[ISL_DW-1:0];
  // squashed slot behaves as no_operation even if its word decodes
  wire logic live = !squash_r;
  wire logic is_inc = live && (kind == ISL_K_INC_SKIP);
  wire logic is_orf = live && (kind == ISL_K_OR_WF);
  wire logic is_mov = live && (kind == ISL_K_MOV_LIT);
  wire logic is_orl = live && (kind == ISL_K_OR_LIT);
  wire logic [ISL_DW-1:0] inc_res = file_rdata + ISL_ONE;
  wire logic [ISL_DW-1:0] orf_res = w_r | file_rdata;
  wire logic [ISL_DW-1:0] orl_res = w_r | lit;
  wire logic [ISL_DW-1:0] res = is_inc ? inc_res : (is_orf ? orf_res : (is_mov ? lit : orl_res));
  wire logic res_zero = (res == ISL_ZERO);
  wire logic to_file = (is_inc || is_orf) && dest_file;
  wire logic to_work = ((is_inc || is_orf) && !dest_file) || is_mov || is_orl;
  wire logic upd_z = is_orf || is_orl; // increment and literal move leave flags
  wire logic take_skip = is_inc && res_zero;

  // phase counter: four clocks per instruction cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      phase_r <= ISL_PH_FIRST;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // instruction register loads at cycle boundary; skip flags the next slot
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ir_r <= ISL_NOP_WORD;
      squash_r <= 1'b1;
    end else if (last_ph) begin
      ir_r <= fetch_word;
      squash_r <= take_skip;
    end
  end

  // work register and write strobes settle in the final phase
  always_ff @(posedge clk) begin
    if (!rstn) begin
      w_r <= ISL_W_RST;
      fwe_r <= 1'b0;
      zwe_r <= 1'b0;
      z_r <= 1'b0;
      fwd_r <= ISL_ZERO;
      faddr_r <= '0;
    end else begin
      fwe_r <= last_ph && to_file;
      zwe_r <= last_ph && upd_z;
      faddr_r <= ir_r[ISL_AW-1:0];
      if (last_ph && to_work) begin
        w_r <= res;
      end
      if (last_ph) begin
        fwd_r <= res;
        z_r <= upd_z ? res_zero : status_z_in;
      end
    end
  end

  assign fetch_req = last_ph;
  // address lags ir_r by one clk so the phase 0 write still hits the old target
  assign file_addr = faddr_r;
  assign file_wdata = fwd_r;
  assign file_we = fwe_r;
  assign work = w_r;
  assign status_z = z_r;
  assign z_we = zwe_r;
  assign skip_active = squash_r;
  assign unknown_op = live && (kind == ISL_K_NONE);

  // results are checked one clk after the phase 3 edge that registers them
  // reset is a level, so every property is quiet while rstn is low

  AST_CYCLE_FOUR: assert property (@(posedge clk) disable iff (!rstn)
    first_ph |-> ##3 last_ph) else $error("instruction cycle not four clocks");
  AST_SKIP_SQUASH: assert property (@(posedge clk) disable iff (!rstn)
    (last_ph && take_skip) |=> squash_r [*4]) else $error("skip slot not a no-op");
  AST_NO_SKIP: assert property (@(posedge clk) disable iff (!rstn)
    (last_ph && is_inc && !res_zero) |=> !squash_r) else $error("skip taken on nonzero");
  AST_INC_FLAGS: assert property (@(posedge clk) disable iff (!rstn)
    (last_ph && (is_inc || is_mov)) |=> !z_we) else $error("flags touched by flagless op");
  AST_ZERO: assert property (@(posedge clk) disable iff (!rstn)
    (last_ph && upd_z) |=> (status_z == (file_wdata == ISL_ZERO))) else $error("zero flag wrong");
  AST_MOV: assert property (@(posedge clk) disable iff (!rstn)
    (last_ph && is_mov) |=> (work == $past(lit))) else $error("literal not loaded");
  AST_INC_DEST: assert property (@(posedge clk) disable iff (!rstn)
    (last_ph && is_inc && dest_file) |=> (file_we && work == $past(w_r))) else $error("inc dest wrong");
  AST_ORL: assert property (@(posedge clk) disable iff (!rstn)
    (last_ph && is_orl) |=> (work == ($past(w_r) | $past(lit)))) else $error("or literal wrong");
  AST_ORF: assert property (@(posedge clk) disable iff (!rstn)
    (last_ph && is_orf && !dest_file) |=> (work == ($past(w_r) | $past(file_rdata)))) else $error("or file wrong");

  // decode: each opcode pattern lands on its own kind
  AST_DEC_INC: assert property (@(posedge clk) disable iff (!rstn)
    (ir_r[ISL_OP6_HI:ISL_OP6_LO] == ISL_OP_INC_SKIP) |-> (kind == ISL_K_INC_SKIP))
    else $error("inc skip not decoded");
  // or with file pattern
  AST_DEC_ORF: assert property (@(posedge clk) disable iff (!rstn)
    (ir_r[ISL_OP6_HI:ISL_OP6_LO] == ISL_OP_OR_WF) |-> (kind == ISL_K_OR_WF))
    else $error("or file not decoded");
  // don't-care bits must not change the move decode
  AST_DEC_MOV: assert property (@(posedge clk) disable iff (!rstn)
    (ir_r[ISL_OP6_HI:ISL_OP4_LO] == ISL_OP_MOV_LIT) |-> (kind == ISL_K_MOV_LIT))
    else $error("move literal not decoded");
  // or literal pattern
  AST_DEC_ORL: assert property (@(posedge clk) disable iff (!rstn)
    (ir_r[ISL_OP6_HI:ISL_OP6_LO] == ISL_OP_OR_LIT) |-> (kind == ISL_K_OR_LIT))
    else $error("or literal not decoded");

  // increment to work leaves the file alone
  AST_INC_WORK: assert property (@(posedge clk) disable iff (!rstn)
    (last_ph && is_inc && !dest_file) |=> (!file_we && (work == ($past(file_rdata) + ISL_ONE))))
    else $error("inc to work wrong");
  // increment to file carries the sum
  AST_INC_DATA: assert property (@(posedge clk) disable iff (!rstn)
    (last_ph && is_inc && dest_file) |=> (file_wdata == ($past(file_rdata) + ISL_ONE)))
    else $error("inc data wrong");
  // write address must not follow the newly loaded word
  AST_ADDR_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    (last_ph && to_file) |=> (file_addr == $past(file_addr)))
    else $error("write address moved");
  // or to file writes the combined value
  AST_ORF_FILE: assert property (@(posedge clk) disable iff (!rstn)
    (last_ph && is_orf && dest_file) |=> (file_we && (file_wdata == ($past(w_r) | $past(file_rdata)))))
    else $error("or file data wrong");
  // or to file keeps work as it was
  AST_ORF_KEEPW: assert property (@(posedge clk) disable iff (!rstn)
    (last_ph && is_orf && dest_file) |=> (work == $past(w_r)))
    else $error("or file touched work");
  // or with file always reports the zero flag
  AST_ORF_ZWE: assert property (@(posedge clk) disable iff (!rstn)
    (last_ph && is_orf) |=> z_we)
    else $error("or file left flag");
  // or literal reports the flag and never writes a file
  AST_ORL_ZWE: assert property (@(posedge clk) disable iff (!rstn)
    (last_ph && is_orl) |=> (z_we && !file_we))
    else $error("or literal strobes wrong");

  // zero flag set on an all-zero literal OR
  AST_ZERO_SET: assert property (@(posedge clk) disable iff (!rstn)
    (last_ph && is_orl && ((w_r | lit) == ISL_ZERO)) |=> status_z)
    else $error("zero flag not set");
  // zero flag cleared on a nonzero file OR
  AST_ZERO_CLR: assert property (@(posedge clk) disable iff (!rstn)
    (last_ph && is_orf && ((w_r | file_rdata) != ISL_ZERO)) |=> !status_z)
    else $error("zero flag not cleared");
  // flagless instructions forward the core's flag untouched
  AST_Z_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    (last_ph && (is_inc || is_mov)) |=> (status_z == $past(status_z_in)))
    else $error("flag changed by flagless op");
  // a squashed slot lasts exactly one instruction cycle
  AST_SKIP_ONCE: assert property (@(posedge clk) disable iff (!rstn)
    (last_ph && squash_r) |=> !squash_r)
    else $error("squash lasted too long");
  // a squashed slot writes nothing at all
  AST_SQUASH_QUIET: assert property (@(posedge clk) disable iff (!rstn)
    (last_ph && squash_r) |=> (!file_we && !z_we && (work == $past(w_r))))
    else $error("squashed slot wrote");
  // non-skipping instructions take a single cycle
  AST_ONE_CYCLE: assert property (@(posedge clk) disable iff (!rstn)
    (last_ph && (is_orf || is_orl || is_mov)) |=> !squash_r)
    else $error("extra cycle on plain op");

  // fetch closes the cycle, next clk starts phase 0
  AST_FETCH_SLOT: assert property (@(posedge clk) disable iff (!rstn)
    fetch_req |=> first_ph)
    else $error("fetch out of phase");
  // write strobe is a single clk
  AST_FWE_PULSE: assert property (@(posedge clk) disable iff (!rstn)
    file_we |=> !file_we)
    else $error("file strobe too long");
  // flag strobe is a single clk
  AST_ZWE_PULSE: assert property (@(posedge clk) disable iff (!rstn)
    z_we |=> !z_we)
    else $error("flag strobe too long");
endmodule
`default_nettype wire

// *** tb/isl_prog_mem.sv ***
/* program memory model that hands instruction words to the exec slice.
   assumes the bench fills mem before reset is released. */
`timescale 1ns/10ps
`default_nettype none
module isl_prog_mem
  import isl_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic fetch_req,
  output logic [ISL_IW-1:0] fetch_word
);
  logic [ISL_IW-1:0] mem [16];
  logic [3:0] pc_r;
  // pointer moves only on a taken fetch, so a squashed word still advances it
  always_ff @(posedge clk) begin
    if (!rstn) pc_r <= 4'h0;
    else if (fetch_req) pc_r <= pc_r + 4'h1;
  end
  assign fetch_word = mem[pc_r];
endmodule
`default_nettype wire

// *** tb/incr_skip_or_literal_exec_tb.sv ***
/* self-checking bench for the four-instruction exec slice.
   assumes the program memory model and the design package are compiled first. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module incr_skip_or_literal_exec_tb;
  import isl_pkg::*;
  logic clk = 0, rstn = 0, status_z_in = 0, fetch_req, file_we, z_we, skip_active, unknown_op, status_z;
  logic [ISL_IW-1:0] fetch_word;
  logic [ISL_DW-1:0] file_rdata = 8'h00, file_wdata, work, last_fw;
  logic [ISL_AW-1:0] file_addr, last_fa;
  int sk_cnt, fr_cnt;
  logic [7:0] zh;
  int error_cnt = 0, num_checks = 0, fw_cnt, z_cnt, cyc = 0;
  always #50 clk = ~clk;
  isl_exec DUT (.clk(clk), .rstn(rstn), .fetch_word(fetch_word), .file_rdata(file_rdata),
    .status_z_in(status_z_in), .fetch_req(fetch_req), .file_addr(file_addr), .file_wdata(file_wdata),
    .file_we(file_we), .work(work), .status_z(status_z), .z_we(z_we), .skip_active(skip_active),
    .unknown_op(unknown_op));
  isl_prog_mem u_mem (.clk(clk), .rstn(rstn), .fetch_req(fetch_req), .fetch_word(fetch_word));
  // log one-clk strobes; a hang is cut short by the cycle ceiling
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin error_cnt++; give_verdict(); end
    if (file_we) begin fw_cnt++; last_fw = file_wdata; last_fa = file_addr; end
    if (rstn && skip_active) sk_cnt++;
    if (fetch_req) fr_cnt++;
    if (z_we) begin z_cnt++; zh = {zh[6:0], status_z}; end
  end
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // reset, load four words padded with no_operation, then let them run out
  task automatic run(input logic [13:0] p[4], input logic [7:0] rd);
    rstn <= 1'b0;
    file_rdata <= rd;
    for (int i = 0; i < 16; i++) u_mem.mem[i] = (i < 4) ? p[i] : ISL_NOP_WORD;
    repeat (10) @(posedge clk);
    fw_cnt = 0; z_cnt = 0; zh = 8'h00; sk_cnt = 0; fr_cnt = 0;
    rstn <= 1'b1;
    repeat (40) @(posedge clk);
    #1;
  endtask
  task automatic t_literal();
    run('{14'h3300, 14'h3800, 14'h32a5, 14'h385a}, 8'h00);
    `CHK(work, 8'hff)
    `CHK(zh[1:0], 2'b10)
    `CHK(z_cnt, 2)
    `CHK(fw_cnt, 0)
    `CHK(sk_cnt, 4)
    `CHK(fr_cnt, 10)
    $display("t_literal done");
  endtask
  task automatic t_or_file();
    run('{14'h3012, 14'h0485, 14'h0405, 14'h0000}, 8'h81);
    `CHK(last_fw, 8'h93)
    `CHK(work, 8'h93)
    `CHK(fw_cnt, 1)
    `CHK(zh[1:0], 2'b00)
    $display("t_or_file done");
  endtask
  task automatic t_skip();
    run('{14'h0f85, 14'h3055, 14'h3801, 14'h0000}, 8'hff);
    `CHK(last_fw, 8'h00)
    `CHK(work, 8'h01)
    `CHK(z_cnt, 1)
    `CHK(sk_cnt, 8)
    `CHK(last_fa, 7'h05)
    $display("t_skip done");
  endtask
  task automatic t_noskip();
    status_z_in <= 1'b1;
    run('{14'h0f05, 14'h3802, 14'h0000, 14'h0000}, 8'h10);
    `CHK(work, 8'h13)
    `CHK(status_z, 1'b1)
    `CHK(unknown_op, 1'b1)
    `CHK(fw_cnt, 0)
    $display("t_noskip done");
  endtask
  initial begin
    t_literal();
    t_or_file();
    t_skip();
    t_noskip();
    give_verdict();
  end
endmodule
`default_nettype wire
